// ===== hdl/parallel_port_pin_mux_upper.sv
// Strap-selected mux of four parallel-port pins: general I/O or memory controls
`timescale 1ns/1ps
module parallel_port_pin_mux_upper (
  input wire logic I_SYS_CLK,
  input wire logic I_RST_N,
  input wire logic I_BOOT_STRAP_SELECT,
  input wire logic [ppmux_pkg::NUM_PINS-1:0] I_PIN_IN,
  input wire logic [ppmux_pkg::NUM_PINS-1:0] I_GP_OUT,
  input wire logic [ppmux_pkg::NUM_PINS-1:0] I_GP_DIR,
  input wire ppmux_pkg::mem_ctrl_t I_MEM_CTRL,
  output ppmux_pkg::pin_drive_t O_PIN,
  output logic [ppmux_pkg::NUM_PINS-1:0] O_GP_IN,
  output ppmux_pkg::pin_mode_t O_MODE
);
  import ppmux_pkg::*;

  logic strap1_r;
  logic strap2_r;
  mux_state_t state_r;
  mux_state_t state_nxt;
  pin_mode_t mode_r;
  pin_mode_t mode_nxt;
  logic run;
  logic [NUM_PINS-1:0] mem_val;
  logic [NUM_PINS-1:0] pin_out;
  logic [NUM_PINS-1:0] pin_oe;
  logic [NUM_PINS-1:0] gp_in;

  // No reset here on purpose: the strap must be sampled while reset is held
  always_ff @(posedge I_SYS_CLK) begin
    strap1_r <= I_BOOT_STRAP_SELECT;
    strap2_r <= strap1_r;
  end

  // Mode is caught by the first edge after release, never by the reset itself
  always_comb begin
    state_nxt = state_r;
    mode_nxt = mode_r;
    case (state_r)
      ST_HELD: begin
        mode_nxt = (strap2_r == STRAP_MEM_LEVEL) ? MODE_MEM : MODE_GP;
        state_nxt = ST_RUN;
      end
      ST_RUN: begin
        mode_nxt = mode_r;
      end
      default: begin
        state_nxt = ST_HELD;
      end
    endcase
  end

  always_ff @(posedge I_SYS_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      state_r <= ST_HELD;
      mode_r <= MODE_GP;
    end else begin
      state_r <= state_nxt;
      mode_r <= mode_nxt;
    end
  end

  assign run = (state_r == ST_RUN);

  // Memory signal to pin mapping
  always_comb begin
    mem_val = '0;
    mem_val[PIN_SIX] = I_MEM_CTRL.chip_sel_2;
    mem_val[PIN_SEVEN] = I_MEM_CTRL.chip_sel_3;
    mem_val[PIN_EIGHT] = I_MEM_CTRL.byte_en_0;
    mem_val[PIN_NINE] = I_MEM_CTRL.byte_en_1;
  end

  generate
    for (genvar g = 0; g < NUM_PINS; g++) begin : g_pin
      ppmux_pin_cell u_cell (
        .i_clk(I_SYS_CLK),
        .i_rst_n(I_RST_N),
        .i_run(run),
        .i_mode(mode_r),
        .i_pin_in(I_PIN_IN[g]),
        .i_gp_out(I_GP_OUT[g]),
        .i_gp_dir(I_GP_DIR[g]),
        .i_mem_val(mem_val[g]),
        .o_pin_out(pin_out[g]),
        .o_pin_oe(pin_oe[g]),
        .o_gp_in(gp_in[g])
      );
    end
  endgenerate

  // One driver for the whole pad bundle
  assign O_PIN = pin_drive_t'{out: pin_out, oe: pin_oe};
  assign O_GP_IN = gp_in;
  assign O_MODE = mode_r;

  // Checks

  // Edges since release, saturating, for the timing checks below
  logic [1:0] since_rel_r;
  always_ff @(posedge I_SYS_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      since_rel_r <= 2'h0;
    end else if (since_rel_r != 2'h3) begin
      since_rel_r <= since_rel_r + 2'h1;
    end
  end

  // Pads never driven while reset is low (no disable here)
  a_reset_pins_float: assert property (
    @(posedge I_SYS_CLK) !I_RST_N |-> (pin_oe == '0)
  ) else $error("pad driven during reset");

  a_mode_reset_gp: assert property (
    @(posedge I_SYS_CLK) !I_RST_N |-> (mode_r == MODE_GP)
  ) else $error("mode not cleared during reset");

  a_strap_latched: assert property (
    @(posedge I_SYS_CLK) disable iff (!I_RST_N)
    (state_r == ST_HELD) |=> (mode_r == ((($past(strap2_r)) == STRAP_MEM_LEVEL) ? MODE_MEM : MODE_GP))
  ) else $error("mode not taken from strap at release");

  a_mode_frozen: assert property (
    @(posedge I_SYS_CLK) disable iff (!I_RST_N)
    run |=> $stable(mode_r)
  ) else $error("mode changed after release");

  a_mem_drive_high: assert property (
    @(posedge I_SYS_CLK) disable iff (!I_RST_N)
    (since_rel_r == 2'h1) && (mode_r == MODE_MEM) && (mem_val == '1)
    |=> (pin_oe == '1) && (pin_out == '1)
  ) else $error("memory pins not driving high after release");

  a_mem_oe_hold: assert property (
    @(posedge I_SYS_CLK) disable iff (!I_RST_N)
    (since_rel_r == 2'h3) && (mode_r == MODE_MEM) |-> (pin_oe == '1)
  ) else $error("memory pin released its drive");

  a_gp_input_boot: assert property (
    @(posedge I_SYS_CLK) disable iff (!I_RST_N)
    run && (mode_r == MODE_GP) && (I_GP_DIR == '0) |=> (pin_oe == '0)
  ) else $error("general-purpose line driven without direction set");

  a_gp_dir_follow: assert property (
    @(posedge I_SYS_CLK) disable iff (!I_RST_N)
    run && (mode_r == MODE_GP) |=> (pin_oe == $past(I_GP_DIR))
  ) else $error("general-purpose direction not followed");

  a_cs2_map: assert property (
    @(posedge I_SYS_CLK) disable iff (!I_RST_N)
    run && (mode_r == MODE_MEM) |=> (pin_out[PIN_SIX] == $past(I_MEM_CTRL.chip_sel_2))
  ) else $error("chip select 2 not on pin six");

  a_cs3_map: assert property (
    @(posedge I_SYS_CLK) disable iff (!I_RST_N)
    run && (mode_r == MODE_MEM) |=> (pin_out[PIN_SEVEN] == $past(I_MEM_CTRL.chip_sel_3))
  ) else $error("chip select 3 not on pin seven");

  a_be0_map: assert property (
    @(posedge I_SYS_CLK) disable iff (!I_RST_N)
    run && (mode_r == MODE_MEM) |=> (pin_out[PIN_EIGHT] == $past(I_MEM_CTRL.byte_en_0))
  ) else $error("byte enable 0 not on pin eight");

  a_be1_map: assert property (
    @(posedge I_SYS_CLK) disable iff (!I_RST_N)
    run && (mode_r == MODE_MEM) |=> (pin_out[PIN_NINE] == $past(I_MEM_CTRL.byte_en_1))
  ) else $error("byte enable 1 not on pin nine");

  a_gp_out_map: assert property (
    @(posedge I_SYS_CLK) disable iff (!I_RST_N)
    run && (mode_r == MODE_GP) |=> (pin_out == $past(I_GP_OUT))
  ) else $error("general-purpose data not on pins");

  a_run_by_second: assert property (
    @(posedge I_SYS_CLK) disable iff (!I_RST_N)
    (since_rel_r == 2'h2) |-> run
  ) else $error("function not fixed two edges after release");

  a_float_before_run: assert property (
    @(posedge I_SYS_CLK) disable iff (!I_RST_N)
    !run |=> (pin_oe == '0)
  ) else $error("pad driven before function fixed");

  // Counter guard keeps the reset-time synchroniser contents out of the compare
  a_gp_in_sync: assert property (
    @(posedge I_SYS_CLK) disable iff (!I_RST_N)
    (since_rel_r == 2'h3) |-> (gp_in == $past(I_PIN_IN, 2))
  ) else $error("pad level not returned two edges late");

  c_mem_boot: cover property (
    @(posedge I_SYS_CLK) disable iff (!I_RST_N)
    (since_rel_r == 2'h2) && (mode_r == MODE_MEM) && (pin_oe == '1)
  );

  c_gp_boot: cover property (
    @(posedge I_SYS_CLK) disable iff (!I_RST_N)
    (since_rel_r == 2'h2) && (mode_r == MODE_GP) && (pin_oe == '0)
  );

  c_gp_turnaround: cover property (
    @(posedge I_SYS_CLK) disable iff (!I_RST_N)
    run && (mode_r == MODE_GP) && (pin_oe == '0) ##1 (pin_oe != '0)
  );

  c_mem_strobe: cover property (
    @(posedge I_SYS_CLK) disable iff (!I_RST_N)
    run && (mode_r == MODE_MEM) && (pin_out != '1)
  );

  c_late_strap: cover property (
    @(posedge I_SYS_CLK) disable iff (!I_RST_N)
    run && (mode_r == MODE_MEM) && (strap2_r != STRAP_MEM_LEVEL)
  );

endmodule : parallel_port_pin_mux_upper

// ===== hdl/ppmux_pin_cell.sv
// One muxed pad: input synchroniser and registered drive
`timescale 1ns/1ps
module ppmux_pin_cell (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_run,
  input wire ppmux_pkg::pin_mode_t i_mode,
  input wire logic i_pin_in,
  input wire logic i_gp_out,
  input wire logic i_gp_dir,
  input wire logic i_mem_val,
  output logic o_pin_out,
  output logic o_pin_oe,
  output logic o_gp_in
);
  import ppmux_pkg::*;

  logic sync1_r;
  logic sync2_r;
  logic out_r;
  logic out_nxt;
  logic oe_r;
  logic oe_nxt;

  // Pad drive; held undriven until the function is fixed
  always_comb begin
    out_nxt = MEM_IDLE_LEVEL;
    oe_nxt = OE_OFF;
    if (i_run) begin
      if (i_mode == MODE_MEM) begin
        out_nxt = i_mem_val;
        oe_nxt = OE_ON;
      end else begin
        out_nxt = i_gp_out;
        oe_nxt = i_gp_dir;
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sync1_r <= SYNC_RESET_LEVEL;
      sync2_r <= SYNC_RESET_LEVEL;
      out_r <= MEM_IDLE_LEVEL;
      oe_r <= OE_OFF;
    end else begin
      sync1_r <= i_pin_in;
      sync2_r <= sync1_r;
      out_r <= out_nxt;
      oe_r <= oe_nxt;
    end
  end

  assign o_pin_out = out_r;
  assign o_pin_oe = oe_r;
  assign o_gp_in = sync2_r;

endmodule : ppmux_pin_cell

// ===== shared/ppmux_pkg.sv
// Shared constants and types for the strapped parallel-port pin mux
package ppmux_pkg;

  localparam int unsigned NUM_PINS = 4;

  // Pin positions inside every 4-bit pin vector
  localparam int unsigned PIN_SIX = 0;
  localparam int unsigned PIN_SEVEN = 1;
  localparam int unsigned PIN_EIGHT = 2;
  localparam int unsigned PIN_NINE = 3;

  // Strap level that selects the memory-interface function
  localparam logic STRAP_MEM_LEVEL = 1'h1;

  // Output level loaded by reset and held, undriven, until the function is fixed
  localparam logic MEM_IDLE_LEVEL = 1'h1;

  localparam logic OE_OFF = 1'h0;
  localparam logic OE_ON = 1'h1;
  localparam logic SYNC_RESET_LEVEL = 1'h0;

  typedef enum logic {
    MODE_GP,
    MODE_MEM
  } pin_mode_t;

  typedef enum logic {
    ST_HELD,
    ST_RUN
  } mux_state_t;

  // Memory controller side, one bit for each muxed control signal
  typedef struct packed {
    logic byte_en_1;
    logic byte_en_0;
    logic chip_sel_3;
    logic chip_sel_2;
  } mem_ctrl_t;

  // Pin drive as seen by the pad ring
  typedef struct packed {
    logic [NUM_PINS-1:0] out;
    logic [NUM_PINS-1:0] oe;
  } pin_drive_t;

endpackage : ppmux_pkg

// ===== tb/parallel_port_pin_mux_upper_tb.sv
// Self-checking bench for the strapped pin mux
`timescale 1ns/1ps
module parallel_port_pin_mux_upper_tb;
  import ppmux_pkg::*;
  logic sys_clk = 1'h0;
  // Starts high: an initial low gives the async reset no falling edge
  logic rst_n = 1'h1;
  logic strap = 1'h0;
  logic [3:0] gp_out = 4'h0;
  logic [3:0] gp_dir = 4'h0;
  logic [3:0] board = 4'h0;
  logic [3:0] pin_in;
  mem_ctrl_t mem = 4'hF;
  pin_drive_t pin;
  logic [3:0] gp_in;
  pin_mode_t mode;
  int err_total = 0;
  int num_checks = 0;

  always #20 sys_clk = ~sys_clk;

  parallel_port_pin_mux_upper i_parallel_port_pin_mux_upper (
    .I_SYS_CLK(sys_clk),
    .I_RST_N(rst_n),
    .I_BOOT_STRAP_SELECT(strap),
    .I_PIN_IN(pin_in),
    .I_GP_OUT(gp_out),
    .I_GP_DIR(gp_dir),
    .I_MEM_CTRL(mem),
    .O_PIN(pin),
    .O_GP_IN(gp_in),
    .O_MODE(mode)
  );

  ppmux_board_model i_ppmux_board_model (
    .i_pin(pin),
    .i_board_val(board),
    .o_pin_in(pin_in)
  );

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] t=%0t seen=%0h exp=%0h", $time, seen, exp);
    end
  endtask : check

  task automatic give_verdict();
    $display("checks=%0d errors=%0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : give_verdict

  // Strap held steady for the whole reset so the synchroniser settles
  task automatic boot(input logic lvl);
    @(negedge sys_clk);
    rst_n = 1'h0;
    strap = lvl;
    repeat (6) @(negedge sys_clk);
    check(pin.oe, 4'h0);
    rst_n = 1'h1;
    repeat (2) @(negedge sys_clk);
  endtask : boot

  task automatic test_mem();
    logic [3:0] exp;
    gp_dir = 4'hF;
    gp_out = 4'h0;
    mem = 4'hF;
    boot(1'h1);
    check(mode, MODE_MEM);
    check(pin, 8'hFF);
    for (int i = 0; i < NUM_PINS; i++) begin
      exp = ~(4'h1 << i);
      mem = exp;
      @(negedge sys_clk);
      check(pin, {exp, 4'hF});
    end
    // Late strap change must not remux a running port
    strap = 1'h0;
    mem = 4'hF;
    repeat (4) @(negedge sys_clk);
    check(mode, MODE_MEM);
    check(pin, 8'hFF);
  endtask : test_mem

  task automatic test_gp();
    gp_dir = 4'h0;
    mem = 4'h0;
    boot(1'h0);
    check(mode, MODE_GP);
    check(pin.oe, 4'h0);
    gp_dir = 4'hF;
    gp_out = 4'hA;
    @(negedge sys_clk);
    check(pin, 8'hAF);
    gp_dir = 4'h5;
    board = 4'h9;
    repeat (3) @(negedge sys_clk);
    check(gp_in, 4'h8);
    gp_dir = 4'h0;
    @(negedge sys_clk);
    check(pin.oe, 4'h0);
  endtask : test_gp

  initial begin
    test_mem();
    test_gp();
    give_verdict();
  end

  // Whole run is well under a hundred cycles
  initial begin
    #100000;
    err_total++;
    give_verdict();
  end
endmodule : parallel_port_pin_mux_upper_tb

// ===== tb/ppmux_board_model.sv
// Board-side model of the four muxed pads
`timescale 1ns/1ps
module ppmux_board_model (
  input wire ppmux_pkg::pin_drive_t i_pin,
  input wire logic [ppmux_pkg::NUM_PINS-1:0] i_board_val,
  output logic [ppmux_pkg::NUM_PINS-1:0] o_pin_in
);
  import ppmux_pkg::*;
  // Board drives only floating pads, so a stale level never hides a release
  always_comb begin
    for (int i = 0; i < NUM_PINS; i++) begin
      o_pin_in[i] = i_pin.oe[i] ? i_pin.out[i] : i_board_val[i];
    end
  end
endmodule : ppmux_board_model
